// File: inc/scc_params.svh
// Register map, field positions and reset values of the synth clock control
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
// How it works
// - Supply below battery threshold raises low-battery flag, routed to mapped general pin.
// - With sequencer on, PLL starts in Synth or Rx mode once the oscillator is stable and coarse calibration is done.
// - Reference clock output appears only after stable oscillation.
// - Bit 4 of register 0x59 set selects the external reference input.
// - General pin five carries the reference clock divided by the selected ratio.
// - Clock output enabled from power-on reset, in every mode except Sleep.
// - Coarse VCO calibration once after reset, fine calibration at each PLL start.
// - Sigma-delta modulator has 19 bits; step is reference over two to nineteen.
// - Carrier is step times 24-bit word held in bytes 0x07 to 0x09.
// - Carrier word takes effect only when its low byte is written.
// - With sequencer on, receiver starts once the PLL has locked.
// - Lock indicator goes high in locking range, mappable to general pins.
// - Reference oscillator clocks the synthesizer and all digital logic except the serial link, which runs on the host's serial clock.
// - With 32 MHz reference the step is about 61.0 Hz.

`define SCC_REG_MODE      7'h01
`define SCC_REG_FRF_MSB   7'h07
`define SCC_REG_FRF_MID   7'h08
`define SCC_REG_FRF_LSB   7'h09
`define SCC_REG_MAP       7'h25
`define SCC_REG_MAP2      7'h26
`define SCC_REG_STATUS    7'h27
`define SCC_REG_BAT       7'h28
`define SCC_REG_TEST_GAIN 7'h58
`define SCC_REG_OSC_SRC   7'h59

`define SCC_EXT_REF_BIT   4
`define SCC_SEQ_OFF_BIT   7
`define SCC_MODE_SLEEP    2'h0
`define SCC_MODE_STANDBY  2'h1
`define SCC_MODE_SYNTH    2'h2
`define SCC_MODE_RX       2'h3
`define SCC_FUNC_LOW      2'h0
`define SCC_FUNC_LOCK     2'h1
`define SCC_FUNC_LOWBAT   2'h2
`define SCC_FUNC_RX       2'h3
`define SCC_DIV_MAX       3'h4
`define SCC_DIV_OFF       3'h7
`define SCC_ST_OSC        0
`define SCC_ST_LOCK       1
`define SCC_ST_LOWBAT     2
`define SCC_ST_RX         3

`define SCC_RST_MODE      8'h01
`define SCC_RST_FRF       24'hE4_C000
`define SCC_RST_MAP       8'h00
`define SCC_RST_MAP2      8'h00
`define SCC_RST_BAT       8'h02
`define SCC_RST_TEST_GAIN 8'h1B
`define SCC_RST_OSC_SRC   8'h00

`define SCC_SDM_BITS      19
`define SCC_REF_HZ        32000000
`define SCC_STEP_MILLIHZ  ((64'(`SCC_REF_HZ) * 64'h03E8) / (64'h0001 << `SCC_SDM_BITS))
`endif

// File: inc/scc_pkg.sv
// Types shared by the synth clock control
`default_nettype none
package scc_pkg;
  typedef enum logic [2:0] {
    ST_SLEEP, ST_OSC_WAIT, ST_COARSE, ST_STANDBY, ST_FINE, ST_LOCK_WAIT, ST_RX
  } scc_state_t;
  typedef logic [7:0] scc_byte_t;
endpackage
`default_nettype wire

// File: src/scc_sync.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
`default_nettype none
module scc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("scc_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: src/scc_spi_link.sv
// Register port serial link, running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"
module scc_spi_link (
  input  wire logic       sck_i,
  input  wire logic       nss_n_i,
  input  wire logic       mosi_i,
  input  wire logic       link_rst_i,
  input  wire logic [3:0] status_i,
  input  wire logic [7:0] rd_data_i,
  output logic      [6:0] rd_addr_o,
  output logic      [6:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            wr_tgl_o,
  output logic            miso_o,
  output logic            miso_oe_n_o
);
  logic [3:0] cnt_q;
  logic [6:0] sh_q;
  logic       wnr_q;
  logic       data_q;
  logic [7:0] tx_q;
  logic [3:0] st_meta_q;
  logic [3:0] st_q;
  logic [7:0] rd_byte;

  // Status bits are levels; two link edges settle them well inside the address byte
  always_ff @(posedge sck_i) begin
    st_meta_q <= status_i;
    st_q      <= st_meta_q;
  end

  assign rd_byte = (rd_addr_o == `SCC_REG_STATUS) ? {4'h0, st_q} : rd_data_i;

  always_ff @(posedge sck_i or posedge nss_n_i) begin
    if (nss_n_i) begin
      cnt_q  <= 4'h0;
      data_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 4'hF) ? 4'h8 : cnt_q + 4'h1;
      if (cnt_q == 4'h7) begin
        data_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sck_i) begin
    sh_q <= {sh_q[5:0], mosi_i};
  end

  // Burst access: address steps after every data byte
  always_ff @(posedge sck_i) begin
    if (cnt_q == 4'h7) begin
      wnr_q     <= sh_q[6];
      rd_addr_o <= {sh_q[5:0], mosi_i};
    end else if (cnt_q == 4'hF) begin
      rd_addr_o <= rd_addr_o + 7'h01;
    end
  end

  // Word is held until the next write, long after the toggle has crossed
  always_ff @(posedge sck_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      wr_addr_o <= 7'h00;
      wr_data_o <= 8'h00;
      wr_tgl_o  <= 1'b0;
    end else if (cnt_q == 4'hF && wnr_q) begin
      wr_addr_o <= rd_addr_o;
      wr_data_o <= {sh_q[6:0], mosi_i};
      wr_tgl_o  <= ~wr_tgl_o;
    end
  end

  always_ff @(negedge sck_i or posedge nss_n_i) begin
    if (nss_n_i) begin
      tx_q        <= 8'h00;
      miso_oe_n_o <= 1'b1;
    end else begin
      if (data_q && cnt_q[2:0] == 3'h0) begin
        tx_q <= rd_byte;
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      miso_oe_n_o <= ~(data_q & ~wnr_q);
    end
  end

  assign miso_o = tx_q[7];
endmodule
`default_nettype wire

// File: src/scc_top.sv
// Synth clock control: registers, startup sequencer, clock output and pin routing
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"
module scc_top (
  input  wire logic        CLK_SYS_I,
  input  wire logic        SRST_I,
  input  wire logic        SCK_I,
  input  wire logic        NSS_N_I,
  input  wire logic        MOSI_I,
  output logic             MISO_O,
  output logic             MISO_OE_N_O,
  input  wire logic        OSC_STABLE_I,
  input  wire logic        PLL_IN_RANGE_I,
  input  wire logic        CAL_DONE_I,
  input  wire logic        BAT_LOW_CMP_I,
  output logic             OSC_EN_O,
  output logic             EXT_REF_SEL_O,
  output logic             PLL_EN_O,
  output logic             CAL_COARSE_O,
  output logic             CAL_FINE_O,
  output logic             RX_EN_O,
  output logic      [23:0] FRF_O,
  output logic      [2:0]  BAT_THRESH_O,
  output logic      [7:0]  NOISE_TWEAK_O,
  output logic      [5:0]  GPIO_O
);
  // The crystal clock runs everything here but the serial link, synthesizer reference included

  localparam int unsigned NPINS = 5;
  localparam int unsigned DIVW  = 5;

  if (NPINS > 5 || DIVW <= int'(`SCC_DIV_MAX)) begin : g_chk
    $error("scc_top pin count or divider width out of range");
  end

  scc_pkg::scc_state_t state_q;
  scc_pkg::scc_state_t state_d;

  logic [7:0]  mode_q;
  logic [7:0]  frf_msb_q;
  logic [7:0]  frf_mid_q;
  logic [7:0]  map_q;
  logic [7:0]  map2_q;
  logic [7:0]  bat_q;
  logic [7:0]  osc_src_q;
  logic        commit_q;
  logic        coarse_done_q;
  logic        done_last_q;
  logic        wr_seen_q;
  logic        rst_q;
  logic        lock_q;
  logic        lowbat_q;
  logic        osc_ok_q;
  logic [DIVW-1:0] div_cnt_q;

  logic [4:0]  sync_s;
  logic        osc_s;
  logic        range_s;
  logic        done_s;
  logic        bat_s;
  logic        tgl_s;
  logic        wr_stb;
  logic        done_rise;
  logic        manual;
  logic [1:0]  mode;
  logic        pll_on_d;
  logic        clk_en;
  logic [6:0]  rd_addr;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_tgl;
  logic [7:0]  rd_data;
  logic [9:0]  pin_sel;

  // Register contents as the link reads them
  function automatic scc_pkg::scc_byte_t reg_read(input logic [6:0] a);
    case (a)
      `SCC_REG_MODE:      reg_read = mode_q;
      `SCC_REG_FRF_MSB:   reg_read = frf_msb_q;
      `SCC_REG_FRF_MID:   reg_read = frf_mid_q;
      `SCC_REG_FRF_LSB:   reg_read = FRF_O[7:0];
      `SCC_REG_MAP:       reg_read = map_q;
      `SCC_REG_MAP2:      reg_read = map2_q;
      `SCC_REG_BAT:       reg_read = bat_q;
      `SCC_REG_TEST_GAIN: reg_read = NOISE_TWEAK_O;
      `SCC_REG_OSC_SRC:   reg_read = osc_src_q;
      default:            reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic pin_func(input logic [1:0] f, input logic lock,
                                    input logic lowbat, input logic rx);
    case (f)
      `SCC_FUNC_LOCK:   pin_func = lock;
      `SCC_FUNC_LOWBAT: pin_func = lowbat;
      `SCC_FUNC_RX:     pin_func = rx;
      default:          pin_func = 1'b0;
    endcase
  endfunction

  function automatic logic div_tap(input logic [DIVW-1:0] cnt, input logic [2:0] sel);
    div_tap = (sel <= `SCC_DIV_MAX) ? cnt[sel] : 1'b0;
  endfunction

  // States in which the loop is powered
  function automatic logic pll_running(input scc_pkg::scc_state_t s);
    pll_running = s == scc_pkg::ST_FINE || s == scc_pkg::ST_LOCK_WAIT || s == scc_pkg::ST_RX;
  endfunction

  // Serial link domain
  scc_spi_link u_link (
    .sck_i       (SCK_I),
    .nss_n_i     (NSS_N_I),
    .mosi_i      (MOSI_I),
    .link_rst_i  (rst_q),
    .status_i    ({RX_EN_O, lowbat_q, lock_q, osc_ok_q}),
    .rd_data_i   (rd_data),
    .rd_addr_o   (rd_addr),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data),
    .wr_tgl_o    (wr_tgl),
    .miso_o      (MISO_O),
    .miso_oe_n_o (MISO_OE_N_O)
  );

  // Configuration only changes on host writes, so it is stable while the host reads it.
  // A process, not an assign: it also wakes on registers read inside the function
  always_comb begin
    rd_data = reg_read(rd_addr);
  end

  scc_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_i (CLK_SYS_I),
    .rst_i (SRST_I),
    .d_i   ({wr_tgl, BAT_LOW_CMP_I, CAL_DONE_I, PLL_IN_RANGE_I, OSC_STABLE_I}),
    .q_o   (sync_s)
  );

  assign osc_s   = sync_s[0];
  assign range_s = sync_s[1];
  assign done_s  = sync_s[2];
  assign bat_s   = sync_s[3];
  assign tgl_s   = sync_s[4];

  assign wr_stb    = tgl_s ^ wr_seen_q;
  assign done_rise = done_s & ~done_last_q;
  assign manual    = mode_q[`SCC_SEQ_OFF_BIT];
  assign mode      = mode_q[1:0];

  // Holds the link's write word flops cleared while reset is in force
  always_ff @(posedge CLK_SYS_I) begin
    rst_q       <= SRST_I;
    wr_seen_q   <= SRST_I ? 1'b0 : tgl_s;
    done_last_q <= SRST_I ? 1'b0 : done_s;
  end

  // Register writes
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      mode_q        <= `SCC_RST_MODE;
      frf_msb_q     <= 8'(`SCC_RST_FRF >> 16);
      frf_mid_q     <= 8'(`SCC_RST_FRF >> 8);
      map_q         <= `SCC_RST_MAP;
      map2_q        <= `SCC_RST_MAP2;
      bat_q         <= `SCC_RST_BAT;
      NOISE_TWEAK_O <= `SCC_RST_TEST_GAIN;
      osc_src_q     <= `SCC_RST_OSC_SRC;
    end else if (wr_stb) begin
      case (wr_addr)
        `SCC_REG_MODE:      mode_q        <= wr_data;
        `SCC_REG_FRF_MSB:   frf_msb_q     <= wr_data;
        `SCC_REG_FRF_MID:   frf_mid_q     <= wr_data;
        `SCC_REG_MAP:       map_q         <= wr_data;
        `SCC_REG_MAP2:      map2_q        <= wr_data;
        `SCC_REG_BAT:       bat_q         <= wr_data;
        `SCC_REG_TEST_GAIN: NOISE_TWEAK_O <= wr_data;
        `SCC_REG_OSC_SRC:   osc_src_q     <= wr_data;
        default: ;
      endcase
    end
  end

  // Carrier word reaches the synthesizer as one unit, on the low byte only
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      FRF_O    <= `SCC_RST_FRF;
      commit_q <= 1'b0;
    end else begin
      commit_q <= wr_stb && wr_addr == `SCC_REG_FRF_LSB;
      if (wr_stb && wr_addr == `SCC_REG_FRF_LSB) begin
        FRF_O <= {frf_msb_q, frf_mid_q, wr_data};
      end
    end
  end

  // Step is the reference over two to the modulator width; 32 MHz gives about 61.0 Hz.
  // The fractional arithmetic itself lives in the synthesizer.

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      EXT_REF_SEL_O <= 1'b0;
      BAT_THRESH_O  <= 3'h0;
    end else begin
      EXT_REF_SEL_O <= osc_src_q[`SCC_EXT_REF_BIT];
      BAT_THRESH_O  <= bat_q[2:0];
    end
  end

  // Startup sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      scc_pkg::ST_SLEEP: begin
        if (mode != `SCC_MODE_SLEEP) begin
          state_d = scc_pkg::ST_OSC_WAIT;
        end
      end
      scc_pkg::ST_OSC_WAIT: begin
        // Manual startup leaves the settle wait to the host
        if (osc_s || manual) begin
          state_d = coarse_done_q ? scc_pkg::ST_STANDBY : scc_pkg::ST_COARSE;
        end
      end
      scc_pkg::ST_COARSE: begin
        if (done_rise) begin
          state_d = scc_pkg::ST_STANDBY;
        end
      end
      scc_pkg::ST_STANDBY: begin
        if (mode == `SCC_MODE_SYNTH || mode == `SCC_MODE_RX) begin
          state_d = scc_pkg::ST_FINE;
        end
      end
      scc_pkg::ST_FINE: begin
        if (done_rise) begin
          state_d = scc_pkg::ST_LOCK_WAIT;
        end
      end
      scc_pkg::ST_LOCK_WAIT: begin
        if (mode == `SCC_MODE_STANDBY) begin
          state_d = scc_pkg::ST_STANDBY;
        end else if (mode == `SCC_MODE_RX && (range_s || manual)) begin
          state_d = scc_pkg::ST_RX;
        end
      end
      scc_pkg::ST_RX: begin
        if (mode != `SCC_MODE_RX) begin
          state_d = scc_pkg::ST_LOCK_WAIT;
        end
      end
      default: begin
        state_d = scc_pkg::ST_SLEEP;
      end
    endcase
    // A new carrier restarts the loop with a fresh fine calibration
    if (commit_q && pll_running(state_q)) begin
      state_d = scc_pkg::ST_FINE;
    end
    if (mode == `SCC_MODE_SLEEP) begin
      state_d = scc_pkg::ST_SLEEP;
    end
  end

  assign pll_on_d = pll_running(state_d);

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_q <= scc_pkg::ST_OSC_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Coarse calibration runs once per reset, not on every wake from sleep
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      coarse_done_q <= 1'b0;
    end else if (state_q == scc_pkg::ST_COARSE && done_rise) begin
      coarse_done_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      OSC_EN_O     <= 1'b1;
      PLL_EN_O     <= 1'b0;
      RX_EN_O      <= 1'b0;
      CAL_COARSE_O <= 1'b0;
      CAL_FINE_O   <= 1'b0;
    end else begin
      OSC_EN_O     <= state_d != scc_pkg::ST_SLEEP;
      PLL_EN_O     <= pll_on_d;
      RX_EN_O      <= state_d == scc_pkg::ST_RX;
      CAL_COARSE_O <= state_d == scc_pkg::ST_COARSE && state_q != scc_pkg::ST_COARSE;
      CAL_FINE_O   <= state_d == scc_pkg::ST_FINE &&
                      (state_q != scc_pkg::ST_FINE || commit_q);
    end
  end

  // Lock only counts while the loop is running past its calibration
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      lock_q   <= 1'b0;
      lowbat_q <= 1'b0;
      osc_ok_q <= 1'b0;
    end else begin
      lock_q   <= range_s && (state_d == scc_pkg::ST_LOCK_WAIT ||
                              state_d == scc_pkg::ST_RX);
      lowbat_q <= bat_s;
      // Sleep drops the flag at once, so the clock output stops with the oscillator
      osc_ok_q <= osc_s && state_d != scc_pkg::ST_SLEEP;
    end
  end

  // General pins 0..4 carry the function the map selects
  assign pin_sel = {map2_q[7:6], map_q};

  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
        GPIO_O[g] <= 1'b0;
      end else begin
        GPIO_O[g] <= pin_func(pin_sel[2*g +: 2], lock_q, lowbat_q, RX_EN_O);
      end
    end
  end

  // Clock output on pin five; the fastest ratio is half the reference since it
  // leaves a flop, and the off code saves its switching current
  assign clk_en = osc_ok_q && map2_q[2:0] != `SCC_DIV_OFF;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      div_cnt_q <= '0;
      GPIO_O[5] <= 1'b0;
    end else begin
      // Free running: every tap is a clean square wave whatever the start phase
      div_cnt_q <= div_cnt_q + DIVW'(1);
      GPIO_O[5] <= clk_en && div_tap(div_cnt_q, map2_q[2:0]);
    end
  end
endmodule
`default_nettype wire

// File: verification/scc_host_model.sv
// Host model: serial register port master and calibration engine responder
`timescale 1ns/1ps
`default_nettype none
module scc_host_model (
  input  wire logic clk_i,
  input  wire logic cal_start_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      nss_n_o,
  output logic      mosi_o,
  output logic      cal_done_o
);
  logic [3:0] cal_cnt_q = 4'h0;

  initial begin
    sck_o = 1'b0;
    nss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Calibration takes several cycles and ends with a short high pulse
  always_ff @(posedge clk_i) begin
    if (cal_start_i) begin
      cal_cnt_q <= 4'h9;
    end else if (cal_cnt_q != 4'h0) begin
      cal_cnt_q <= cal_cnt_q - 4'h1;
    end
  end
  assign cal_done_o = (cal_cnt_q != 4'h0) && (cal_cnt_q < 4'h4);

  // Serial clock stands low outside frames; data set while it is low
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [15:0] word;
    word = {wr, addr, wdat};
    rdat = 8'h00;
    nss_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = word[i];
      #3 sck_o = 1'b1;
      if (i < 8) begin
        rdat = {rdat[6:0], miso_i};
      end
      #3 sck_o = 1'b0;
    end
    #3 nss_n_o = 1'b1;
    // A released data line must not keep showing its last bit
    mosi_o = ~mosi_o;
  endtask
endmodule
`default_nettype wire

// File: verification/scc_top_props.sv
// Checker for startup sequencing, calibration pulses and clock output gating
`timescale 1ns/1ps
`default_nettype none
module scc_top_props (
  input  wire logic       CLK_SYS_I,
  input  wire logic       SRST_I,
  input  wire logic       OSC_STABLE_I,
  input  wire logic       PLL_IN_RANGE_I,
  input  wire logic       OSC_EN_O,
  input  wire logic       PLL_EN_O,
  input  wire logic       CAL_COARSE_O,
  input  wire logic       CAL_FINE_O,
  input  wire logic       RX_EN_O,
  input  wire logic [5:0] GPIO_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SRST_I);

  logic [1:0] coarse_cnt_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      coarse_cnt_q <= 2'h0;
    end else if (CAL_COARSE_O && coarse_cnt_q != 2'h3) begin
      coarse_cnt_q <= coarse_cnt_q + 2'h1;
    end
  end

  sequence lock_seen;
    PLL_EN_O && $past(PLL_IN_RANGE_I, 2);
  endsequence

  reference_clock_output_gate_a : assert property (
    $changed(GPIO_O[5]) |-> $past(OSC_STABLE_I, 2)) else $error("clock output ran early");
  sleep_quiet_a : assert property (
    !OSC_EN_O && !$past(OSC_EN_O, 4) |-> $stable(GPIO_O[5])) else $error("clock out in sleep");
  coarse_once_a : assert property (
    CAL_COARSE_O |-> coarse_cnt_q == 2'h0) else $error("second coarse calibration");
  fine_pll_a : assert property (
    CAL_FINE_O |-> ##[0:1] PLL_EN_O) else $error("fine calibration without pll");
  fine_single_a : assert property (
    CAL_FINE_O |=> !CAL_FINE_O) else $error("fine calibration pulse too long");
  pll_after_osc_a : assert property (
    $rose(PLL_EN_O) |-> $past(OSC_STABLE_I, 2)) else $error("pll before oscillator");
  rx_after_lock_a : assert property (
    $rose(RX_EN_O) |-> lock_seen) else $error("receiver before lock");
  osc_en_run_a : assert property (
    PLL_EN_O || RX_EN_O |-> OSC_EN_O) else $error("running without oscillator");
endmodule

bind scc_top scc_top_props scc_top_props_inst (
  .CLK_SYS_I      (CLK_SYS_I),
  .SRST_I         (SRST_I),
  .OSC_STABLE_I   (OSC_STABLE_I),
  .PLL_IN_RANGE_I (PLL_IN_RANGE_I),
  .OSC_EN_O       (OSC_EN_O),
  .PLL_EN_O       (PLL_EN_O),
  .CAL_COARSE_O   (CAL_COARSE_O),
  .CAL_FINE_O     (CAL_FINE_O),
  .RX_EN_O        (RX_EN_O),
  .GPIO_O         (GPIO_O)
);
`default_nettype wire

// File: verification/synth_clock_control_bench.sv
// Self-checking bench for the synth clock control
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"
module synth_clock_control_bench;
  logic        clk = 1'b0;
  logic        srst, osc_ok, in_range, bat_low;
  logic        sck, nss_n, mosi, miso, miso_oe_n, cal_done;
  logic        osc_en, ext_ref, pll_en, cal_c, cal_f, rx_en;
  logic [23:0] frf;
  logic [2:0]  bat_th;
  logic [7:0]  tweak;
  logic [5:0]  gpio;
  int          failures = 0;
  int          cmp_count = 0;
  int          coarse_n = 0;
  int          fine_n = 0;
  int          r;
  logic [6:0]  ra [9] = '{7'h01, 7'h07, 7'h08, 7'h09, 7'h27, 7'h28, 7'h58, 7'h59, 7'h7F};
  logic [7:0]  rv [9] = '{8'h01, 8'hE4, 8'hC0, 8'h00, 8'h00, 8'h02, 8'h1B, 8'h00, 8'h00};

  always #5 clk = ~clk;

  scc_top scc_top_inst (
    .CLK_SYS_I(clk), .SRST_I(srst), .SCK_I(sck), .NSS_N_I(nss_n), .MOSI_I(mosi),
    .MISO_O(miso), .MISO_OE_N_O(miso_oe_n), .OSC_STABLE_I(osc_ok),
    .PLL_IN_RANGE_I(in_range), .CAL_DONE_I(cal_done), .BAT_LOW_CMP_I(bat_low),
    .OSC_EN_O(osc_en), .EXT_REF_SEL_O(ext_ref), .PLL_EN_O(pll_en), .CAL_COARSE_O(cal_c),
    .CAL_FINE_O(cal_f), .RX_EN_O(rx_en), .FRF_O(frf), .BAT_THRESH_O(bat_th),
    .NOISE_TWEAK_O(tweak), .GPIO_O(gpio));

  scc_host_model scc_host_model_inst (
    .clk_i(clk), .cal_start_i(cal_c | cal_f), .miso_i(miso), .sck_o(sck),
    .nss_n_o(nss_n), .mosi_o(mosi), .cal_done_o(cal_done));

  always @(posedge clk) begin
    if (cal_c === 1'b1) coarse_n++;
    if (cal_f === 1'b1) fine_n++;
  end

  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Writes need several system cycles to land before the next one
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    scc_host_model_inst.xfer(1'b1, a, d, q);
    cyc(8);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    scc_host_model_inst.xfer(1'b0, a, 8'h00, q);
    cyc(2);
    check("register read", 24'(q), 24'(e));
  endtask

  task automatic clk_rises(input int n, output int cnt);
    logic prev;
    cnt = 0;
    prev = gpio[5];
    repeat (n) begin
      cyc(1);
      if (gpio[5] === 1'b1 && prev === 1'b0) cnt++;
      prev = gpio[5];
    end
  endtask

  initial begin
    #300000;
    failures++;
    give_verdict();
  end

  initial begin
    srst <= 1'b1;
    osc_ok <= 1'b0;
    in_range <= 1'b0;
    bat_low <= 1'b0;
    cyc(12);
    check("miso idle", 24'(miso_oe_n), 24'h00_0001);
    check("step tenths", 24'(`SCC_STEP_MILLIHZ / 64'h0064), 24'h00_0262);
    check("osc_en reset", 24'(osc_en), 24'h00_0001);
    check("frf reset", frf, 24'hE4_C000);
    check("pll reset", 24'(pll_en), 24'h00_0000);
    @(posedge clk) srst <= 1'b0;
    cyc(4);
    for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    check("miso released", 24'(miso_oe_n), 24'h00_0001);
    clk_rises(20, r);
    check("reference_clock_output before osc", 24'(r), 24'h00_0000);
    @(posedge clk) osc_ok <= 1'b1;
    cyc(40);
    check("coarse cal", 24'(coarse_n), 24'h00_0001);
    // Host watches the clock output before relying on the oscillator
    for (int d = 0; d < 8; d++) begin
      wr_reg(7'h26, 8'(d));
      clk_rises(64, r);
      check("divider", 24'(r), (d < 5) ? 24'(64 >> (d + 1)) : 24'h00_0000);
    end
    wr_reg(7'h26, 8'h00);
    wr_reg(7'h59, 8'h10);
    check("ext ref", 24'(ext_ref), 24'h00_0001);
    rd_chk(7'h59, 8'h10);
    wr_reg(7'h07, 8'h6C);
    wr_reg(7'h08, 8'h80);
    check("frf upper only", frf, 24'hE4_C000);
    wr_reg(7'h09, 8'h12);
    check("frf commit", frf, 24'h6C_8012);
    rd_chk(7'h08, 8'h80);
    wr_reg(7'h25, 8'h39);
    wr_reg(7'h01, 8'h03);
    check("fine cal", 24'(fine_n), 24'h00_0001);
    check("pll on", 24'(pll_en), 24'h00_0001);
    cyc(30);
    check("lock low", 24'(gpio[0]), 24'h00_0000);
    check("rx wait", 24'(rx_en), 24'h00_0000);
    @(posedge clk) in_range <= 1'b1;
    cyc(8);
    check("lock pin", 24'(gpio[0]), 24'h00_0001);
    check("rx on", 24'(rx_en), 24'h00_0001);
    check("rx pin", 24'(gpio[2]), 24'h00_0001);
    wr_reg(7'h09, 8'h34);
    check("relock pin", 24'(gpio[0]), 24'h00_0000);
    check("fine again", 24'(fine_n), 24'h00_0002);
    cyc(30);
    check("lock back", 24'(gpio[0]), 24'h00_0001);
    @(posedge clk) bat_low <= 1'b1;
    cyc(6);
    check("lowbat pin", 24'(gpio[1]), 24'h00_0001);
    rd_chk(7'h27, 8'h0F);
    @(posedge clk) bat_low <= 1'b0;
    cyc(6);
    check("lowbat clear", 24'(gpio[1]), 24'h00_0000);
    wr_reg(7'h28, 8'h05);
    check("bat thresh", 24'(bat_th), 24'h00_0005);
    wr_reg(7'h58, 8'h2D);
    check("noise tweak", 24'(tweak), 24'h00_002D);
    wr_reg(7'h01, 8'h00);
    check("sleep osc", 24'(osc_en), 24'h00_0000);
    check("sleep rx", 24'(rx_en), 24'h00_0000);
    clk_rises(20, r);
    check("sleep reference_clock_output", 24'(r), 24'h00_0000);
    check("coarse once", 24'(coarse_n), 24'h00_0001);
    give_verdict();
  end
endmodule
`default_nettype wire
